// >>> inc/pmt_pkg.sv
/*
 * package for the program memory table read block: sizes, the reset
 * entry point, page layout and the table operation codes.
 * assumes nothing of its surroundings.
 */
package pmt_pkg;
  localparam int unsigned WordWidth   = 16;
  localparam int unsigned AddrWidth   = 16;
  localparam int unsigned MemDepth    = 49152;    // 48K words
  localparam int unsigned BankCount   = 6;        // banks 0 to 5
  localparam int unsigned BankWords   = 8192;
  localparam logic [15:0] ResetVector = 16'h0000;
  localparam logic [7:0]  LastPage    = 8'hbf;    // final page of store
  localparam logic [7:0]  HighMaskRst = 8'hff;    // all high bits implemented
  localparam logic [15:0] WordRst     = 16'h0000;
  localparam logic [7:0]  ByteRst     = 8'h00;
  localparam int unsigned TableCycles = 2;

  typedef enum logic [1:0] {
    PMT_OP_PAGE,      // page-relative, sector 0 destination
    PMT_OP_LAST,      // last-page, sector 0 destination
    PMT_OP_EXT_PAGE,  // ext_page_table_read
    PMT_OP_EXT_LAST   // ext_last_page_table_read
  } pmt_op_type;
endpackage : pmt_pkg

// >>> src/pmt_sync3.sv
/*
 * three flip-flop synchroniser for a level from a pin; the output moves
 * only once the second and third stages agree.
 * assumes the pin is asynchronous to clock.
 */
`timescale 1ns/100ps
`default_nettype none
module pmt_sync3 (
  // clock and reset
  input  wire logic clock,
  input  wire logic rst,
  // level in and out
  input  wire logic pinIn,
  output logic      levelOut
);
  logic s1_q, s2_q, s3_q, lvl_q;
  logic s1_d, s2_d, s3_d, lvl_d;

  // next values: first stage only feeds the second
  always_comb begin
    s1_d  = pinIn;
    s2_d  = s1_q;
    s3_d  = s2_q;
    lvl_d = (s2_q == s3_q) ? s3_q : lvl_q;
  end

  // registers
  always_ff @(posedge clock) begin
    if (rst) begin
      s1_q  <= 1'b0;
      s2_q  <= 1'b0;
      s3_q  <= 1'b0;
      lvl_q <= 1'b0;
    end else begin
      s1_q  <= s1_d;
      s2_q  <= s2_d;
      s3_q  <= s3_d;
      lvl_q <= lvl_d;
    end
  end

  assign levelOut = lvl_q;
endmodule : pmt_sync3
`default_nettype wire

// >>> src/pmt_store.sv
/*
 * program store array, one synchronous read port and one write port.
 * addresses beyond the store are dropped on load and read back as zero.
 */
`timescale 1ns/100ps
`default_nettype none
module pmt_store (
  // clock
  input  wire logic                            clock,
  // read port
  input  wire logic [pmt_pkg::AddrWidth-1:0]   rdAddr,
  output logic      [pmt_pkg::WordWidth-1:0]   rdData,
  // load port
  input  wire logic                            wrEn,
  input  wire logic [pmt_pkg::AddrWidth-1:0]   wrAddr,
  input  wire logic [pmt_pkg::WordWidth-1:0]   wrData
);
  import pmt_pkg::*;
  // six banks of 8K words, addressed flat
  logic [WordWidth-1:0] mem [0:MemDepth-1];
  logic [WordWidth-1:0] rd_q;

  // read is registered, which is why table reads take a second cycle
  always_ff @(posedge clock) begin
    if (wrEn && (wrAddr < AddrWidth'(MemDepth))) begin
      mem[wrAddr] <= wrData;
    end
    rd_q <= (rdAddr < AddrWidth'(MemDepth)) ? mem[rdAddr] : WordRst;
  end

  assign rdData = rd_q;
endmodule : pmt_store
`default_nettype wire

// >>> src/pmt_table_read.sv
/*
 * program memory fetch and table read unit: instruction fetch by the
 * program counter and two-cycle table reads that return the low byte for
 * a destination register and keep the high byte in a holding latch.
 * assumes the core issues a table op only while tableBusy is low, holds
 * the pointer bytes itself, and the serial pins go to an external engine.
 */
//
// Summary of operation
// - the store holds 48K words of 16 bits in six banks 0 to 5.
// - after reset fetching starts at address zero.
// - the table address joins the high pointer byte and the low byte.
// - a table read sends the low byte to the named register, the high
//      byte to the holding latch.
// - unimplemented high-byte bits read back as zero.
// - the page form uses the low byte as offset in the page chosen by high.
// - the last-page form ignores the high byte and uses the final page.
// - destinations outside sector 0 use the extended forms, same transfer.
// - software can read and write the holding latch.
// - every table instruction takes two instruction cycles.
// - programming uses an input serial clock and one two-way data line.
// - the debug data pin is two-way and the debug clock is an input.
`timescale 1ns/100ps
`default_nettype none
module pmt_table_read (
  // clock and reset
  input  wire logic                          clock,
  input  wire logic                          rst,
  // instruction fetch
  input  wire logic                          fetchReq,
  input  wire logic                          jumpEn,
  input  wire logic [pmt_pkg::AddrWidth-1:0] jumpAddr,
  output logic      [pmt_pkg::AddrWidth-1:0] progCounter,
  output logic      [pmt_pkg::WordWidth-1:0] instrWord,
  output logic                               instrValid,
  // table read request
  input  wire logic                          tableReq,
  input  wire pmt_pkg::pmt_op_type           tableOp,
  input  wire logic [7:0]                    tablePtrLow,
  input  wire logic [7:0]                    tablePtrHigh,
  input  wire logic [7:0]                    destSel,
  output logic                               tableBusy,
  output logic                               tableDone,
  output logic      [7:0]                    destData,
  output logic      [7:0]                    destAddr,
  output logic                               destExt,
  // holding latch access
  input  wire logic                          latchWrEn,
  input  wire logic [7:0]                    latchWrData,
  output logic      [7:0]                    tableHighByteLatch,
  // store load from the programming engine
  input  wire logic                          loadEn,
  input  wire logic [pmt_pkg::AddrWidth-1:0] loadAddr,
  input  wire logic [pmt_pkg::WordWidth-1:0] loadData,
  // programming serial pins
  input  wire logic                          progSerialClockPin,
  input  wire logic                          progSerialDataPinIn,
  input  wire logic                          progSerialDataPinOut,
  input  wire logic                          progSerialDataPinDrive,
  output logic                               progSerialClock,
  output logic                               progSerialData,
  output logic                               progSerialDataOut,
  output logic                               progSerialDataOe,
  // debug serial pins
  input  wire logic                          debugSerialClockPin,
  input  wire logic                          debugSerialDataPinIn,
  output logic                               debugSerialClock,
  output logic                               debugSerialData,
  output logic                               debugSerialDataOut,
  output logic                               debugSerialDataOe
);
  import pmt_pkg::*;

  // the store has one read port; a table read borrows it for one cycle,
  // so a fetch or jump asked for then is dropped and the core must hold
  // its request until tableBusy falls again
  typedef enum {PMT_IDLE, PMT_WAIT} pmt_state_type;

  pmt_state_type        state_q, state_d;
  logic [AddrWidth-1:0] pc_q, pc_d;
  logic [AddrWidth-1:0] rdAddr;
  logic [WordWidth-1:0] rdData;
  logic                 fetchPend_q, fetchPend_d;
  logic                 instrValid_q, instrValid_d;
  logic [WordWidth-1:0] instr_q, instr_d;
  logic                 done_q, done_d;
  logic [7:0]           destData_q, destData_d;
  logic [7:0]           destAddr_q, destAddr_d;
  logic                 destExt_q, destExt_d;
  logic [7:0]           destHold_q, destHold_d;
  logic                 extHold_q, extHold_d;
  logic [7:0]           latch_q, latch_d;
  logic [AddrWidth-1:0] tableAddr;
  logic                 opExt;
  logic                 opLast;
  logic                 busy_q, busy_d;
  // registered pin drive copies
  logic                 pOut_q, pOut_d;
  logic                 pOe_q, pOe_d;
  logic                 dOut_q, dOut_d;
  logic                 dOe_q, dOe_d;

  // program store, 48K x 16 in six banks
  pmt_store u_store (
    .clock  (clock),
    .rdAddr (rdAddr),
    .rdData (rdData),
    .wrEn   (loadEn),
    .wrAddr (loadAddr),
    .wrData (loadData)
  );

  // serial pin inputs come from outside the clock domain
  pmt_sync3 u_prog_clk (
    .clock    (clock),
    .rst      (rst),
    .pinIn    (progSerialClockPin),
    .levelOut (progSerialClock)
  );
  pmt_sync3 u_prog_dat (
    .clock    (clock),
    .rst      (rst),
    .pinIn    (progSerialDataPinIn),
    .levelOut (progSerialData)
  );
  pmt_sync3 u_dbg_clk (
    .clock    (clock),
    .rst      (rst),
    .pinIn    (debugSerialClockPin),
    .levelOut (debugSerialClock)
  );
  pmt_sync3 u_dbg_dat (
    .clock    (clock),
    .rst      (rst),
    .pinIn    (debugSerialDataPinIn),
    .levelOut (debugSerialData)
  );

  // table address forming; pointer bytes are only read, never written
  always_comb begin
    opExt  = (tableOp == PMT_OP_EXT_PAGE) || (tableOp == PMT_OP_EXT_LAST);
    opLast = (tableOp == PMT_OP_LAST) || (tableOp == PMT_OP_EXT_LAST);
    if (opLast) begin
      tableAddr = {LastPage, tablePtrLow};
    end else begin
      tableAddr = {tablePtrHigh, tablePtrLow};
    end
    // a table read owns the port in its first cycle; fetch waits
    if (state_q == PMT_IDLE && tableReq) begin
      rdAddr = tableAddr;
    end else begin
      rdAddr = pc_q;
    end
  end

  // next state of the sequencer, fetch path and latch
  always_comb begin
    state_d      = state_q;
    pc_d         = pc_q;
    fetchPend_d  = 1'b0;
    instrValid_d = 1'b0;
    instr_d      = instr_q;
    done_d       = 1'b0;
    destData_d   = destData_q;
    destAddr_d   = destAddr_q;
    destExt_d    = destExt_q;
    destHold_d   = destHold_q;
    extHold_d    = extHold_q;
    latch_d      = latch_q;
    if (latchWrEn) begin
      latch_d = latchWrData;
    end
    if (fetchPend_q) begin
      instr_d      = rdData;
      instrValid_d = 1'b1;
    end
    case (state_q)
      PMT_IDLE: begin
        if (tableReq) begin
          destHold_d = destSel;
          extHold_d  = opExt;
          state_d    = PMT_WAIT;
        end else if (jumpEn) begin
          pc_d = jumpAddr;
        end else if (fetchReq) begin
          fetchPend_d = 1'b1;
          pc_d        = pc_q + AddrWidth'(1);
        end
      end
      PMT_WAIT: begin
        // second cycle: word arrives, bytes split out
        destData_d = rdData[7:0];
        destAddr_d = destHold_q;
        destExt_d  = extHold_q;
        latch_d    = rdData[15:8] & HighMaskRst;
        done_d     = 1'b1;
        state_d    = PMT_IDLE;
      end
      default: begin
        state_d = PMT_IDLE;
      end
    endcase
    // busy is a flop of its own so the core sees a clean level, not a
    // decode of the state register
    busy_d = (state_d == PMT_WAIT);
  end

  // registers; reset puts the program counter on the reset entry point
  always_ff @(posedge clock) begin
    if (rst) begin
      state_q      <= PMT_IDLE;
      busy_q       <= 1'b0;
      pc_q         <= ResetVector;
      fetchPend_q  <= 1'b0;
      instrValid_q <= 1'b0;
      instr_q      <= WordRst;
      done_q       <= 1'b0;
      destData_q   <= ByteRst;
      destAddr_q   <= ByteRst;
      destExt_q    <= 1'b0;
      destHold_q   <= ByteRst;
      extHold_q    <= 1'b0;
      latch_q      <= ByteRst;
    end else begin
      state_q      <= state_d;
      busy_q       <= busy_d;
      pc_q         <= pc_d;
      fetchPend_q  <= fetchPend_d;
      instrValid_q <= instrValid_d;
      instr_q      <= instr_d;
      done_q       <= done_d;
      destData_q   <= destData_d;
      destAddr_q   <= destAddr_d;
      destExt_q    <= destExt_d;
      destHold_q   <= destHold_d;
      extHold_q    <= extHold_d;
      latch_q      <= latch_d;
    end
  end

  // two-way data pins: the external engine decides drive; the debug data
  // pin shares the programming data line, so it mirrors the same request.
  // limitation: the serial protocol itself lives outside this block
  always_comb begin
    pOut_d = progSerialDataPinOut;
    pOe_d  = progSerialDataPinDrive;
    dOut_d = progSerialDataPinOut;
    dOe_d  = progSerialDataPinDrive;
  end

  // pin registers; reset releases both data pins
  always_ff @(posedge clock) begin
    if (rst) begin
      pOut_q <= 1'b0;
      pOe_q  <= 1'b0;
      dOut_q <= 1'b0;
      dOe_q  <= 1'b0;
    end else begin
      pOut_q <= pOut_d;
      pOe_q  <= pOe_d;
      dOut_q <= dOut_d;
      dOe_q  <= dOe_d;
    end
  end

  // outputs straight from flip-flops
  assign progCounter        = pc_q;
  assign instrWord          = instr_q;
  assign instrValid         = instrValid_q;
  assign tableBusy          = busy_q;
  assign tableDone          = done_q;
  assign destData           = destData_q;
  assign destAddr           = destAddr_q;
  assign destExt            = destExt_q;
  assign tableHighByteLatch = latch_q;
  assign progSerialDataOut  = pOut_q;
  assign progSerialDataOe   = pOe_q;
  assign debugSerialDataOut = dOut_q;
  assign debugSerialDataOe  = dOe_q;
endmodule : pmt_table_read
`default_nettype wire

// >>> tb/pmt_monitor.sv
/*
 * checker for the table read unit: request timing, flags, latch, fetch.
 * assumes it is bound to every pmt_table_read instance.
 */
`timescale 1ns/100ps
`default_nettype none
module pmt_monitor (
  // clock and reset
  input wire logic                clock,
  input wire logic                rst,
  // table side
  input wire logic                tableReq,
  input wire pmt_pkg::pmt_op_type tableOp,
  input wire logic                tableBusy,
  input wire logic                tableDone,
  input wire logic                destExt,
  input wire logic                latchWrEn,
  input wire logic [7:0]          latchWrData,
  input wire logic [7:0]          tableHighByteLatch,
  // fetch side
  input wire logic                fetchReq,
  input wire logic                jumpEn,
  input wire logic [15:0]         jumpAddr,
  input wire logic [15:0]         progCounter,
  input wire logic                instrValid
);
  import pmt_pkg::*;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // a request only counts while the unit is idle
  wire logic taken = tableReq && !tableBusy;
  wire logic fetchGo = fetchReq && !tableBusy && !tableReq && !jumpEn;

  req_busy_a: assert property (taken |=> tableBusy && !tableDone)
    else $error("busy missing after table request");
  done_delay_a: assert property (taken |-> ##2 tableDone && !tableBusy)
    else $error("table read not done in two cycles");
  done_pulse_a: assert property (tableDone |=> !tableDone)
    else $error("done held longer than one cycle");
  ext_flag_a: assert property (taken |-> ##2 destExt == $past(tableOp[1], 2))
    else $error("extended flag does not follow the op");
  reset_entry_a: assert property ($fell(rst) |-> progCounter == ResetVector)
    else $error("fetch does not start at the reset entry");
  latch_write_a: assert property (latchWrEn && !tableBusy |=>
    tableHighByteLatch == $past(latchWrData))
    else $error("software latch write lost");
  fetch_step_a: assert property (fetchGo |=>
    progCounter == $past(progCounter) + 16'h0001)
    else $error("counter did not step on fetch");
  fetch_answer_a: assert property (fetchGo |-> ##2 instrValid)
    else $error("fetched word not delivered");
  jump_load_a: assert property (jumpEn && !tableBusy && !tableReq |=>
    progCounter == $past(jumpAddr))
    else $error("jump address not loaded");
endmodule : pmt_monitor

bind pmt_table_read pmt_monitor mon (.*);
`default_nettype wire

// >>> tb/pmt_core_model.sv
/*
 * core model: issues table reads and keeps the data register file.
 * assumes the caller starts issue just after a rising clock edge.
 */
`timescale 1ns/100ps
`default_nettype none
module pmt_core_model (
  // clock
  input wire logic                 clock,
  // request to the unit
  output logic                     tableReq,
  output pmt_pkg::pmt_op_type      tableOp,
  output logic [7:0]               tablePtrLow,
  output logic [7:0]               tablePtrHigh,
  output logic [7:0]               destSel,
  // answer from the unit
  input wire logic                 tableDone,
  input wire logic [7:0]           destData,
  input wire logic [7:0]           destAddr
);
  import pmt_pkg::*;
  logic [7:0] regFile [256];
  initial begin
    tableReq = 1'b0;
    tableOp = PMT_OP_PAGE;
    {tablePtrLow, tablePtrHigh, destSel} = 24'h000000;
  end
  // pointer bytes live here; a read never writes them back
  task automatic issue(input pmt_op_type op, input logic [7:0] hi, lo, dst);
    tableReq <= 1'b1;
    tableOp <= op;
    tablePtrHigh <= hi;
    tablePtrLow <= lo;
    destSel <= dst;
    @(posedge clock);
    tableReq <= 1'b0;
    @(posedge clock);
  endtask : issue
  // a finished read lands in the register the unit names
  always @(posedge clock) begin
    if (tableDone) regFile[destAddr] <= destData;
  end
endmodule : pmt_core_model
`default_nettype wire

// >>> tb/testbench.sv
/*
 * testbench for the table read unit with a core model on the far side.
 * assumes the store loads through the programming engine port.
 */
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import pmt_pkg::*;
  logic clock, rst, fetchReq, jumpEn, latchWrEn, loadEn, instrValid;
  logic tableReq, tableBusy, tableDone, destExt;
  logic [15:0] jumpAddr, loadAddr, loadData, progCounter, instrWord;
  logic [7:0] latchWrData, tableHighByteLatch, destData, destAddr;
  logic [7:0] tablePtrLow, tablePtrHigh, destSel;
  pmt_op_type tableOp;
  logic progSerialClockPin, progSerialDataPinIn, progSerialDataPinOut;
  logic progSerialDataPinDrive, debugSerialClockPin, debugSerialDataPinIn;
  logic progSerialClock, progSerialData, progSerialDataOut, progSerialDataOe;
  logic debugSerialClock, debugSerialData, debugSerialDataOut;
  logic debugSerialDataOe;
  int miscompares, samplesChecked;
  // c000 lies past the store, so its load must vanish
  logic [15:0] ldAddr [7] = '{16'h0000, 16'h0001, 16'h1234, 16'hbf06,
                             16'hbf05, 16'hbfff, 16'hc000};
  logic [15:0] ldData [7] = '{16'ha5c3, 16'h1e2d, 16'h7f81, 16'h001a,
                             16'h000f, 16'hff5a, 16'hdead};

  pmt_table_read dut (.*);
  pmt_core_model core (.*);

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  task automatic check(input string name, input logic [15:0] seen, exp);
    samplesChecked++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic conclude();
    $display("checks %0d mismatches %0d", samplesChecked, miscompares);
    if (miscompares == 0 && samplesChecked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : conclude

  // one table read through the core, judged once the register is written
  task automatic tread(input pmt_op_type op, input logic [7:0] hi, lo, dst,
                       input logic [15:0] word);
    @(posedge clock);
    core.issue(op, hi, lo, dst);
    repeat (2) @(posedge clock);
    @(negedge clock);
    check("dest byte", core.regFile[dst], word[7:0]);
    check("high latch", tableHighByteLatch, word[15:8]);
    check("ext flag", destExt, op[1]);
  endtask : tread

  task automatic load_store();
    for (int i = 0; i < 7; i++) begin
      @(posedge clock);
      loadEn <= 1'b1;
      loadAddr <= ldAddr[i];
      loadData <= ldData[i];
    end
    @(posedge clock);
    loadEn <= 1'b0;
  endtask : load_store

  task automatic test_table();
    tread(PMT_OP_PAGE, 8'h12, 8'h34, 8'h10, 16'h7f81);
    tread(PMT_OP_LAST, 8'h12, 8'h06, 8'h11, 16'h001a);
    tread(PMT_OP_PAGE, 8'hc0, 8'h00, 8'h12, 16'h0000);
    tread(PMT_OP_EXT_LAST, 8'h00, 8'hff, 8'h91, 16'hff5a);
  endtask : test_table

  // two reads at the fastest legal spacing
  task automatic test_back();
    @(posedge clock);
    core.issue(PMT_OP_EXT_PAGE, 8'hbf, 8'h05, 8'h90);
    core.issue(PMT_OP_PAGE, 8'h00, 8'h01, 8'h92);
    repeat (2) @(posedge clock);
    @(negedge clock);
    check("first dest", core.regFile[8'h90], 16'h000f);
    check("second dest", core.regFile[8'h92], 16'h002d);
    check("second high", tableHighByteLatch, 16'h001e);
  endtask : test_back

  task automatic test_latch();
    @(posedge clock);
    latchWrEn <= 1'b1;
    latchWrData <= 8'ha3;
    @(posedge clock);
    latchWrEn <= 1'b0;
    @(negedge clock);
    check("latch write", tableHighByteLatch, 16'h00a3);
    tread(PMT_OP_PAGE, 8'h12, 8'h34, 8'h13, 16'h7f81);
  endtask : test_latch

  task automatic test_fetch();
    @(posedge clock);
    fetchReq <= 1'b1;
    @(posedge clock);
    fetchReq <= 1'b0;
    @(posedge clock);
    @(negedge clock);
    check("entry word", instrWord, 16'ha5c3);
    check("entry valid", instrValid, 16'h0001);
    @(posedge clock);
    jumpEn <= 1'b1;
    jumpAddr <= 16'hbfff;
    @(posedge clock);
    jumpEn <= 1'b0;
    fetchReq <= 1'b1;
    @(posedge clock);
    fetchReq <= 1'b0;
    repeat (2) @(posedge clock);
    @(negedge clock);
    check("last word", instrWord, 16'hff5a);
    check("counter", progCounter, 16'hc000);
  endtask : test_fetch

  task automatic test_pins();
    @(posedge clock);
    {progSerialClockPin, progSerialDataPinIn, progSerialDataPinOut} <= 3'h7;
    {progSerialDataPinDrive, debugSerialClockPin} <= 2'h3;
    debugSerialDataPinIn <= 1'b1;
    repeat (5) @(posedge clock);
    @(negedge clock);
    check("pins", {progSerialClock, progSerialData, progSerialDataOut,
      progSerialDataOe, debugSerialClock, debugSerialData,
      debugSerialDataOut, debugSerialDataOe}, 16'h00ff);
  endtask : test_pins

  // a second reset mid-run must put fetching back on the entry point
  task automatic test_reset();
    @(posedge clock);
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    @(negedge clock);
    check("rerun counter", progCounter, ResetVector);
    check("rerun latch", tableHighByteLatch, 16'h0000);
    @(posedge clock);
    fetchReq <= 1'b1;
    @(posedge clock);
    fetchReq <= 1'b0;
    @(posedge clock);
    @(negedge clock);
    check("rerun word", instrWord, 16'ha5c3);
  endtask : test_reset

  // main sequence: reset, load, then each scenario
  initial begin
    {rst, fetchReq, jumpEn, latchWrEn, loadEn} = 5'h10;
    {jumpAddr, loadAddr, loadData, latchWrData} = 56'h0;
    {progSerialClockPin, progSerialDataPinIn, progSerialDataPinOut} = 3'h0;
    {progSerialDataPinDrive, debugSerialClockPin} = 2'h0;
    debugSerialDataPinIn = 1'b0;
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    @(negedge clock);
    check("reset counter", progCounter, ResetVector);
    load_store();
    test_table();
    test_back();
    test_latch();
    test_fetch();
    test_reset();
    test_pins();
    conclude();
  end

  // watchdog well past the seventy or so cycles the scenarios need
  initial begin
    repeat (3000) @(posedge clock);
    miscompares++;
    conclude();
  end
endmodule : testbench
`default_nettype wire
